// file: rtl/switch_interrupt_mask_latch.sv
// interrupt masking, event latching and register access of the quad switch
`timescale 1ns/1ps

// Summary of operation
// - pin request mask, set bit drives alert
// - request sources in fixed bit order
// - serial warning mask gates reply warning code
// - pin warning mask gates alert pin
// - warning sources in fixed bit order
// - commanded safe mode raises no event
// - any channel over threshold raises source
// - request and warning status registers readable
// - status bits stay set until cleared
// - status read returns content then clears
// - status resets zero, high bits unused
// - control registers 8-bit write and readback
// - control registers load defaults at reset
// - global control at 00h resets 20h
// - reply code none, warning, request, invalid
// - pending enabled interrupt pulls alert low
// - serial request mask gates request code
module switch_interrupt_mask_latch
  import switch_irq_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input switch_irq_pkg::reg_access_s ACCESS,
  input switch_irq_pkg::request_src_s REQ_SRC,
  input switch_irq_pkg::warning_src_s WARN_SRC,
  input wire logic FRAME_ERROR,
  output logic [13:0] RD_DATA,
  output logic RD_VALID,
  output logic [1:0] REPLY_STATUS_CODE,
  output logic FAULT_O,
  output logic FAULT_OE,
  output logic [7:0] GLOBAL_CONTROL
);
  import switch_irq_pkg::*;

  logic [7:0] global_control_reg;
  logic [7:0] request_serial_mask_reg;
  logic [7:0] request_pin_mask_reg;
  logic [7:0] warning_serial_mask_reg;
  logic [7:0] warning_pin_mask_reg;
  logic [13:0] rd_data_reg;
  logic rd_valid_reg;
  logic [1:0] reply_code_reg;
  logic fault_oe_reg;
  logic invalid_reg;
  logic [7:0] req_set;
  logic [7:0] warn_set;
  logic [7:0] req_status;
  logic [7:0] warn_status;
  logic req_clear;
  logic warn_clear;
  logic wr_global;
  logic wr_req_serial;
  logic wr_req_pin;
  logic wr_warn_serial;
  logic wr_warn_pin;
  logic wr_bad;
  logic rd_ctrl_ok;
  logic rd_diag_ok;
  logic rd_bad;
  logic access_ok;
  logic pin_alert;
  logic [1:0] code;
  logic [7:0] ctrl_rd_value;

  // request sources, one bit per class
  always_comb begin
    req_set = SOURCE_RESET;
    req_set[REQ_CHARGE_PUMP] = REQ_SRC.charge_pump;
    req_set[REQ_WD_TIMEOUT] = REQ_SRC.watchdog_timeout;
    req_set[REQ_TOGGLE_ERROR] = REQ_SRC.toggle_error;
    req_set[REQ_SAFE_MODE] = REQ_SRC.safe_mode_entry & ~REQ_SRC.safe_mode_by_cmd;
    req_set[REQ_OVERTEMP] = any_channel(REQ_SRC.overtemp);
    req_set[REQ_RETRY_SHORT] = any_channel(REQ_SRC.retry_or_short);
    req_set[REQ_OVERLOAD] = any_channel(REQ_SRC.overload);
  end

  // warning sources, one bit per class
  always_comb begin
    warn_set = SOURCE_RESET;
    warn_set[WARN_WD] = WARN_SRC.watchdog_warning;
    warn_set[WARN_OVERTEMP] = any_channel(WARN_SRC.overtemp);
    warn_set[WARN_OVERCURRENT] = any_channel(WARN_SRC.overcurrent);
    warn_set[WARN_UNDERCURRENT] = any_channel(WARN_SRC.undercurrent);
    warn_set[WARN_OVERVOLTAGE] = any_channel(WARN_SRC.overvoltage);
    warn_set[WARN_UNDERVOLTAGE] = any_channel(WARN_SRC.undervoltage);
    warn_set[WARN_LOGIC_UV] = WARN_SRC.logic_supply_uv;
    warn_set[WARN_MAIN_SUPPLY_UV] = WARN_SRC.main_supply_uv;
  end

  // write address decode
  always_comb begin
    wr_global = 1'b0;
    wr_req_serial = 1'b0;
    wr_req_pin = 1'b0;
    wr_warn_serial = 1'b0;
    wr_warn_pin = 1'b0;
    wr_bad = 1'b0;
    if (!ACCESS.wr) begin
      wr_bad = 1'b0;
    end else if (ACCESS.addr == GLOBAL_CONTROL_ADDR) begin
      wr_global = 1'b1;
    end else if (ACCESS.addr == REQUEST_SERIAL_MASK_ADDR) begin
      wr_req_serial = 1'b1;
    end else if (ACCESS.addr == REQUEST_PIN_MASK_ADDR) begin
      wr_req_pin = 1'b1;
    end else if (ACCESS.addr == WARNING_SERIAL_MASK_ADDR) begin
      wr_warn_serial = 1'b1;
    end else if (ACCESS.addr == WARNING_PIN_MASK_ADDR) begin
      wr_warn_pin = 1'b1;
    end else begin
      wr_bad = 1'b1;
    end
  end

  // read address decode and control readback mux
  always_comb begin
    rd_ctrl_ok = 1'b0;
    rd_diag_ok = 1'b0;
    rd_bad = 1'b0;
    req_clear = 1'b0;
    warn_clear = 1'b0;
    ctrl_rd_value = MASK_RESET;
    if (!ACCESS.rd || ACCESS.wr) begin
      rd_bad = 1'b0;
    end else if (ACCESS.ctrl_sel && ACCESS.addr == GLOBAL_CONTROL_ADDR) begin
      rd_ctrl_ok = 1'b1;
      ctrl_rd_value = global_control_reg;
    end else if (ACCESS.ctrl_sel && ACCESS.addr == REQUEST_SERIAL_MASK_ADDR) begin
      rd_ctrl_ok = 1'b1;
      ctrl_rd_value = request_serial_mask_reg;
    end else if (ACCESS.ctrl_sel && ACCESS.addr == REQUEST_PIN_MASK_ADDR) begin
      rd_ctrl_ok = 1'b1;
      ctrl_rd_value = request_pin_mask_reg;
    end else if (ACCESS.ctrl_sel && ACCESS.addr == WARNING_SERIAL_MASK_ADDR) begin
      rd_ctrl_ok = 1'b1;
      ctrl_rd_value = warning_serial_mask_reg;
    end else if (ACCESS.ctrl_sel && ACCESS.addr == WARNING_PIN_MASK_ADDR) begin
      rd_ctrl_ok = 1'b1;
      ctrl_rd_value = warning_pin_mask_reg;
    end else if (!ACCESS.ctrl_sel && ACCESS.addr == REQUEST_STATUS_ADDR) begin
      rd_diag_ok = 1'b1;
      req_clear = 1'b1;
    end else if (!ACCESS.ctrl_sel && ACCESS.addr == WARNING_STATUS_ADDR) begin
      rd_diag_ok = 1'b1;
      warn_clear = 1'b1;
    end else begin
      rd_bad = 1'b1;
    end
  end

  assign access_ok = (ACCESS.wr & ~wr_bad) | rd_ctrl_ok | rd_diag_ok;

  event_latch #(
    .W(SRC_W)
  ) u_request_latch (
    .clk(CLK),
    .rstn(RSTN),
    .set(req_set),
    .clear(req_clear),
    .q(req_status)
  );

  event_latch #(
    .W(SRC_W)
  ) u_warning_latch (
    .clk(CLK),
    .rstn(RSTN),
    .set(warn_set),
    .clear(warn_clear),
    .q(warn_status)
  );

  alert_encoder u_alert_encoder (
    .req_status(req_status),
    .warn_status(warn_status),
    .req_serial_mask(request_serial_mask_reg),
    .req_pin_mask(request_pin_mask_reg),
    .warn_serial_mask(warning_serial_mask_reg),
    .warn_pin_mask(warning_pin_mask_reg),
    .invalid(invalid_reg),
    .pin_alert(pin_alert),
    .code(code)
  );

  // control registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      global_control_reg <= GLOBAL_CONTROL_RESET;
      request_serial_mask_reg <= MASK_RESET;
      request_pin_mask_reg <= MASK_RESET;
      warning_serial_mask_reg <= MASK_RESET;
      warning_pin_mask_reg <= MASK_RESET;
    end else begin
      if (wr_global) begin
        global_control_reg <= ACCESS.data;
      end
      if (wr_req_serial) begin
        request_serial_mask_reg <= ACCESS.data;
      end
      if (wr_req_pin) begin
        request_pin_mask_reg <= ACCESS.data;
      end
      if (wr_warn_serial) begin
        warning_serial_mask_reg <= ACCESS.data;
      end
      if (wr_warn_pin) begin
        warning_pin_mask_reg <= ACCESS.data;
      end
    end
  end

  // invalid access flag, reported on the next reply, set wins over clear
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      invalid_reg <= 1'b0;
    end else if (wr_bad || rd_bad || FRAME_ERROR) begin
      invalid_reg <= 1'b1;
    end else if (access_ok) begin
      invalid_reg <= 1'b0;
    end
  end

  // read data path
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rd_data_reg <= READ_DATA_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_ctrl_ok | rd_diag_ok;
      if (rd_ctrl_ok) begin
        rd_data_reg <= {STATUS_UNUSED_HIGH, ctrl_rd_value};
      end else if (req_clear) begin
        rd_data_reg <= {STATUS_UNUSED_HIGH, req_status};
      end else if (warn_clear) begin
        rd_data_reg <= {STATUS_UNUSED_HIGH, warn_status};
      end
    end
  end

  // reply code and open-drain alert
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      reply_code_reg <= CODE_NONE;
      fault_oe_reg <= 1'b0;
    end else begin
      reply_code_reg <= code;
      fault_oe_reg <= pin_alert;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign RD_VALID = rd_valid_reg;
  assign REPLY_STATUS_CODE = reply_code_reg;
  assign FAULT_O = 1'b0;
  assign FAULT_OE = fault_oe_reg;
  assign GLOBAL_CONTROL = global_control_reg;

  pin_request_a: assert property (@(posedge CLK) disable iff (!RSTN)
    |(req_status & request_pin_mask_reg) |=> FAULT_OE)
    else $error("masked request did not pull alert");

  pin_quiet_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!(|(req_status & request_pin_mask_reg)) && !(|(warn_status & warning_pin_mask_reg)))
    |=> !FAULT_OE)
    else $error("alert active without enabled source");

  pin_warning_a: assert property (@(posedge CLK) disable iff (!RSTN)
    |(warn_status & warning_pin_mask_reg) |=> FAULT_OE)
    else $error("masked warning did not pull alert");

  warn_code_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!invalid_reg && !(|(req_status & request_serial_mask_reg))
     && |(warn_status & warning_serial_mask_reg)) |=> REPLY_STATUS_CODE == CODE_WARNING)
    else $error("warning code missing");

  request_priority_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!invalid_reg && |(req_status & request_serial_mask_reg))
    |=> REPLY_STATUS_CODE == CODE_REQUEST)
    else $error("request code missing or not prior");

  invalid_code_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (wr_bad || rd_bad) |=> ##1 REPLY_STATUS_CODE == CODE_INVALID)
    else $error("invalid access not reported");

  commanded_safe_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!req_status[REQ_SAFE_MODE] && REQ_SRC.safe_mode_entry && REQ_SRC.safe_mode_by_cmd)
    |=> !req_status[REQ_SAFE_MODE])
    else $error("commanded safe mode raised an event");

  channel_any_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (WARN_SRC.overcurrent != 4'h0) |=> warn_status[WARN_OVERCURRENT])
    else $error("overcurrent on one channel not latched");

  sticky_status_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!req_clear && !warn_clear) |=> ((req_status & $past(req_status)) == $past(req_status))
    && ((warn_status & $past(warn_status)) == $past(warn_status)))
    else $error("status bit lost without read");

  read_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (req_clear && req_set == SOURCE_RESET)
    |=> RD_VALID && RD_DATA[7:0] == $past(req_status) && req_status == SOURCE_RESET)
    else $error("status read did not return and clear");

  set_wins_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (warn_clear && warn_set[WARN_WD]) |=> warn_status[WARN_WD])
    else $error("event lost during clearing read");

  high_bits_a: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_VALID |-> RD_DATA[13:8] == STATUS_UNUSED_HIGH)
    else $error("unused status bits not zero");

  reset_default_a: assert property (@(posedge CLK)
    !RSTN |=> GLOBAL_CONTROL == GLOBAL_CONTROL_RESET && request_pin_mask_reg == MASK_RESET
    && warning_serial_mask_reg == MASK_RESET && req_status == SOURCE_RESET)
    else $error("reset defaults not loaded");

  readback_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_req_pin ##1 (ACCESS.rd && ACCESS.ctrl_sel && !ACCESS.wr
    && ACCESS.addr == REQUEST_PIN_MASK_ADDR) |=> RD_DATA[7:0] == $past(ACCESS.data, 2))
    else $error("control readback mismatch");

  frame_invalid_a: assert property (@(posedge CLK) disable iff (!RSTN)
    FRAME_ERROR |=> ##1 REPLY_STATUS_CODE == CODE_INVALID)
    else $error("frame error not reported");

  read_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (rd_ctrl_ok || rd_diag_ok) |=> RD_VALID)
    else $error("valid read not answered");

  refused_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    rd_bad |=> !RD_VALID)
    else $error("refused read answered");

  none_code_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!invalid_reg && !(|(req_status & request_serial_mask_reg))
     && !(|(warn_status & warning_serial_mask_reg))) |=> REPLY_STATUS_CODE == CODE_NONE)
    else $error("code set without enabled source");

  alert_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (pin_alert && !req_clear && !warn_clear && !wr_req_pin && !wr_warn_pin) |=> pin_alert)
    else $error("alert dropped without clearing read");

endmodule

// file: rtl/switch_irq_pkg.sv
// shared constants, field layouts and carrier structs of the switch interrupt block
package switch_irq_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int STATUS_W = 14;
  localparam int SRC_W = 8;
  localparam int CHANNELS = 4;

  localparam logic [5:0] GLOBAL_CONTROL_ADDR = 6'h00;
  localparam logic [5:0] REQUEST_STATUS_ADDR = 6'h06;
  localparam logic [5:0] WARNING_STATUS_ADDR = 6'h07;
  localparam logic [5:0] REQUEST_SERIAL_MASK_ADDR = 6'h10;
  localparam logic [5:0] REQUEST_PIN_MASK_ADDR = 6'h11;
  localparam logic [5:0] WARNING_SERIAL_MASK_ADDR = 6'h12;
  localparam logic [5:0] WARNING_PIN_MASK_ADDR = 6'h13;

  localparam logic [7:0] GLOBAL_CONTROL_RESET = 8'h20;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [13:0] READ_DATA_RESET = 14'h0000;
  localparam logic [5:0] STATUS_UNUSED_HIGH = 6'h00;

  localparam int REQ_CHARGE_PUMP = 7;
  localparam int REQ_UNUSED = 6;
  localparam int REQ_WD_TIMEOUT = 5;
  localparam int REQ_TOGGLE_ERROR = 4;
  localparam int REQ_SAFE_MODE = 3;
  localparam int REQ_OVERTEMP = 2;
  localparam int REQ_RETRY_SHORT = 1;
  localparam int REQ_OVERLOAD = 0;

  localparam int WARN_WD = 7;
  localparam int WARN_OVERTEMP = 6;
  localparam int WARN_OVERCURRENT = 5;
  localparam int WARN_UNDERCURRENT = 4;
  localparam int WARN_OVERVOLTAGE = 3;
  localparam int WARN_UNDERVOLTAGE = 2;
  localparam int WARN_LOGIC_UV = 1;
  localparam int WARN_MAIN_SUPPLY_UV = 0;

  localparam logic [1:0] CODE_NONE = 2'b00;
  localparam logic [1:0] CODE_WARNING = 2'b01;
  localparam logic [1:0] CODE_REQUEST = 2'b10;
  localparam logic [1:0] CODE_INVALID = 2'b11;

  typedef struct packed {
    logic charge_pump;
    logic watchdog_timeout;
    logic toggle_error;
    logic safe_mode_entry;
    logic safe_mode_by_cmd;
    logic [3:0] overtemp;
    logic [3:0] retry_or_short;
    logic [3:0] overload;
  } request_src_s;

  typedef struct packed {
    logic watchdog_warning;
    logic [3:0] overtemp;
    logic [3:0] overcurrent;
    logic [3:0] undercurrent;
    logic [3:0] overvoltage;
    logic [3:0] undervoltage;
    logic logic_supply_uv;
    logic main_supply_uv;
  } warning_src_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic ctrl_sel;
    logic [5:0] addr;
    logic [7:0] data;
  } reg_access_s;

  function automatic logic any_channel(input logic [3:0] ch);
    any_channel = |ch;
  endfunction

endpackage

// file: rtl/event_latch.sv
// sticky event status register, cleared as a whole, set wins over clear
`timescale 1ns/1ps
module event_latch #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] set,
  input wire logic clear,
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    if (clear) begin
      q_next = set;
    end else begin
      q_next = q_reg | set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// file: rtl/alert_encoder.sv
// combines latched status with masks into alert level and reply status code
`timescale 1ns/1ps
module alert_encoder
  import switch_irq_pkg::*;
(
  input wire logic [7:0] req_status,
  input wire logic [7:0] warn_status,
  input wire logic [7:0] req_serial_mask,
  input wire logic [7:0] req_pin_mask,
  input wire logic [7:0] warn_serial_mask,
  input wire logic [7:0] warn_pin_mask,
  input wire logic invalid,
  output logic pin_alert,
  output logic [1:0] code
);
  logic req_serial;
  logic warn_serial;

  assign pin_alert = |(req_status & req_pin_mask) | |(warn_status & warn_pin_mask);
  assign req_serial = |(req_status & req_serial_mask);
  assign warn_serial = |(warn_status & warn_serial_mask);

  always_comb begin
    if (invalid) begin
      code = CODE_INVALID;
    end else if (req_serial) begin
      code = CODE_REQUEST;
    end else if (warn_serial) begin
      code = CODE_WARNING;
    end else begin
      code = CODE_NONE;
    end
  end
endmodule

// file: bench/host_model.sv
// host side model issuing decoded register reads and writes
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output switch_irq_pkg::reg_access_s access,
  input wire logic [13:0] rd_data,
  input wire logic rd_valid
);
  import switch_irq_pkg::*;

  initial access = '0;

  // strobe stands through the taking edge, then wr and rd drop to 0 and ctrl_sel, addr and data go to their inverse
  task automatic xfer(input logic wr, input logic sel, input logic [5:0] addr,
      input logic [7:0] data, output logic [13:0] rdata, output logic ok);
    @(posedge clk);
    access <= '{wr: wr, rd: !wr, ctrl_sel: sel, addr: addr, data: data};
    @(posedge clk);
    access <= '{wr: 1'b0, rd: 1'b0, ctrl_sel: !sel, addr: ~addr, data: ~data};
    #1;
    ok = rd_valid;
    rdata = rd_data;
  endtask

  // control write then its readback on the very next edge
  task automatic wr_rd(input logic [5:0] addr, input logic [7:0] data,
      output logic [13:0] rdata, output logic ok);
    @(posedge clk);
    access <= '{wr: 1'b1, rd: 1'b0, ctrl_sel: 1'b1, addr: addr, data: data};
    @(posedge clk);
    access <= '{wr: 1'b0, rd: 1'b1, ctrl_sel: 1'b1, addr: addr, data: ~data};
    @(posedge clk);
    access <= '{wr: 1'b0, rd: 1'b0, ctrl_sel: 1'b0, addr: ~addr, data: data};
    #1;
    ok = rd_valid;
    rdata = rd_data;
  endtask
endmodule

// file: bench/tb_switch_interrupt_mask_latch.sv
// self-checking bench of the switch interrupt mask and latch block
`timescale 1ns/1ps
module tb_switch_interrupt_mask_latch;
  import switch_irq_pkg::*;
  logic clk;
  logic rstn;
  reg_access_s access;
  request_src_s req_src;
  warning_src_s warn_src;
  logic frame_error;
  logic [13:0] rd_data;
  logic rd_valid;
  logic [1:0] code;
  logic fault_o;
  logic fault_oe;
  logic [7:0] glb;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h82516a7e;
  logic [7:0] m [4];
  // open-drain alert with pull-up
  wire fault_pin = fault_oe ? fault_o : 1'b1;

  switch_interrupt_mask_latch dut (.CLK(clk), .RSTN(rstn), .ACCESS(access),
    .REQ_SRC(req_src), .WARN_SRC(warn_src), .FRAME_ERROR(frame_error),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .REPLY_STATUS_CODE(code),
    .FAULT_O(fault_o), .FAULT_OE(fault_oe), .GLOBAL_CONTROL(glb));

  host_model host (.clk(clk), .access(access), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic request_src_s req_of(input int b, input logic [3:0] ch);
    request_src_s s;
    s = '0;
    case (b)
      7: s.charge_pump = 1'b1;
      5: s.watchdog_timeout = 1'b1;
      4: s.toggle_error = 1'b1;
      3: s.safe_mode_entry = 1'b1;
      2: s.overtemp = ch;
      1: s.retry_or_short = ch;
      default: s.overload = ch;
    endcase
    return s;
  endfunction

  function automatic warning_src_s warn_of(input int b, input logic [3:0] ch);
    warning_src_s s;
    s = '0;
    case (b)
      7: s.watchdog_warning = 1'b1;
      6: s.overtemp = ch;
      5: s.overcurrent = ch;
      4: s.undercurrent = ch;
      3: s.overvoltage = ch;
      2: s.undervoltage = ch;
      1: s.logic_supply_uv = 1'b1;
      default: s.main_supply_uv = 1'b1;
    endcase
    return s;
  endfunction

  function automatic logic [1:0] exp_code(input logic [7:0] rs, input logic [7:0] ws);
    if (|(rs & m[0])) return CODE_REQUEST;
    if (|(ws & m[2])) return CODE_WARNING;
    return CODE_NONE;
  endfunction

  function automatic logic exp_pin(input logic [7:0] rs, input logic [7:0] ws);
    return !(|(rs & m[1]) || |(ws & m[3]));
  endfunction

  task automatic chk_val(input string name, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [13:0] d;
    logic ok;
    host.xfer(1'b1, 1'b1, a, v, d, ok);
  endtask

  task automatic rdchk(input string name, input logic sel, input logic [5:0] a,
      input logic [13:0] exp);
    logic [13:0] d;
    logic ok;
    host.xfer(1'b0, sel, a, 8'h00, d, ok);
    chk_bit(name, 1'b1, ok);
    chk_val(name, exp, d);
  endtask

  task automatic set_masks(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      m[i] = v[8*i +: 8];
      wr(6'h10 + 6'(i), m[i]);
      rdchk("mask readback", 1'b1, 6'h10 + 6'(i), {6'h00, m[i]});
    end
  endtask

  task automatic pulse(input request_src_s r, input warning_src_s w, input logic fe);
    @(posedge clk);
    req_src <= r;
    warn_src <= w;
    frame_error <= fe;
    @(posedge clk);
    req_src <= '0;
    warn_src <= '0;
    frame_error <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] rs;
    logic [7:0] ws;
    logic [13:0] d;
    logic ok;
    logic [7:0] gcv;
    request_src_s s;
    rstn = 1'b0;
    req_src = '0;
    warn_src = '0;
    frame_error = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdchk("global control", 1'b1, 6'h00, 14'h0020);
    chk_val("global control port", 14'h0020, {6'h00, glb});
    for (int i = 0; i < 4; i++) rdchk("mask reset", 1'b1, 6'h10 + 6'(i), 14'h0000);
    rdchk("request status reset", 1'b0, 6'h06, 14'h0000);
    rdchk("warning status reset", 1'b0, 6'h07, 14'h0000);
    chk_val("reply code idle", CODE_NONE, code);
    chk_bit("alert pin idle", 1'b1, fault_pin);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(6'h00, r[7:0]);
      gcv = r[7:0];
      rdchk("global control", 1'b1, 6'h00, {6'h00, r[7:0]});
      chk_val("global control port", {6'h00, r[7:0]}, {6'h00, glb});
    end
    r = rnd();
    host.wr_rd(6'h11, r[7:0], d, ok);
    chk_bit("pin mask back to back valid", 1'b1, ok);
    chk_val("pin mask back to back", {6'h00, r[7:0]}, d);
    for (int pass = 0; pass < 2; pass++) begin
      for (int cls = 0; cls < 2; cls++) begin
        for (int b = 0; b < 8; b++) begin
          if (cls == 0 && b == 6) continue;
          set_masks(pass == 0 ? 32'hffffffff : rnd());
          r = rnd();
          rs = (cls == 0) ? 8'h01 << b : 8'h00;
          ws = (cls == 1) ? 8'h01 << b : 8'h00;
          pulse(cls == 0 ? req_of(b, 4'h1 << r[1:0]) : '0,
            cls == 1 ? warn_of(b, 4'h1 << r[1:0]) : '0, 1'b0);
          chk_val("reply code", exp_code(rs, ws), code);
          chk_bit("alert pin", exp_pin(rs, ws), fault_pin);
          rdchk("request status", 1'b0, 6'h06, {6'h00, rs});
          rdchk("warning status", 1'b0, 6'h07, {6'h00, ws});
          rdchk("request status cleared", 1'b0, 6'h06, 14'h0000);
          chk_val("reply code cleared", CODE_NONE, code);
          chk_bit("alert pin cleared", 1'b1, fault_pin);
        end
      end
    end
    set_masks(32'hffffffff);
    s = req_of(3, 4'h0);
    s.safe_mode_by_cmd = 1'b1;
    pulse(s, '0, 1'b0);
    chk_bit("alert pin commanded safe mode", 1'b1, fault_pin);
    rdchk("request status commanded", 1'b0, 6'h06, 14'h0000);
    pulse(req_of(0, 4'hf), warn_of(0, 4'h0), 1'b0);
    chk_val("reply code priority", CODE_REQUEST, code);
    rdchk("request status", 1'b0, 6'h06, 14'h0001);
    rdchk("warning status", 1'b0, 6'h07, 14'h0001);
    set_masks(32'h00ff0000);
    pulse(req_of(0, 4'h8), warn_of(1, 4'h0), 1'b0);
    chk_val("reply code masked request", CODE_WARNING, code);
    chk_bit("alert pin masked", 1'b1, fault_pin);
    rdchk("masked request still latched", 1'b0, 6'h06, 14'h0001);
    rdchk("warning status", 1'b0, 6'h07, 14'h0002);
    fork
      host.xfer(1'b0, 1'b0, 6'h07, 8'h00, d, ok);
      pulse('0, warn_of(7, 4'h0), 1'b0);
    join
    chk_val("read beside event", 14'h0000, d);
    chk_val("reply code set wins", CODE_WARNING, code);
    rdchk("event kept over clear", 1'b0, 6'h07, 14'h0080);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: host.xfer(1'b0, 1'b1, 6'h05, 8'h00, d, ok);
        1: host.xfer(1'b1, 1'b1, 6'h06, 8'h5a, d, ok);
        2: host.xfer(1'b0, 1'b0, 6'h10, 8'h00, d, ok);
        default: pulse('0, '0, 1'b1);
      endcase
      if (i < 3) chk_bit("refused read answered", 1'b0, ok);
      @(posedge clk);
      #1;
      chk_val("reply code invalid", CODE_INVALID, code);
      rdchk("global control", 1'b1, 6'h00, {6'h00, gcv});
      @(posedge clk);
      #1;
      chk_val("reply code after valid access", CODE_NONE, code);
    end
    end_of_test();
  end
endmodule
